/* File: bench/passive_serial_config_sequencer_tb.sv */
// self-checking bench for the configuration sequencer with a host model
// assumes shortened power-on, restart and user-clock counts set below
`timescale 1ns/10ps
module passive_serial_config_sequencer_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic supplies_valid = 1'b0;
  logic config_request_n = 1'b1;
  logic [2:0] scheme_select_pins = 3'h0;
  logic use_user_init_clock = 1'b0;
  logic user_init_clock = 1'b0;
  logic usr_en = 1'b0;
  logic core_load_done = 1'b0;
  logic core_word_ready = 1'b0;
  logic send = 1'b0;
  logic [31:0] word = 32'h0;
  logic config_clock, busy, ready_status_out, ready_status_oe_n;
  logic load_complete, user_mode, core_word_valid, load_overrun, ready_line;
  logic [31:0] config_data;
  psc_pkg::psc_word_t core_word_data;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;

  // ---------------------------------------------------------------
  // clocks, wired-or ready line, hang guard
  // ---------------------------------------------------------------
  always #25 mclk = ~mclk;
  // user clock at 4 mclk periods, below the mclk/2 sampling limit; idles low until enabled
  always #100 user_init_clock = usr_en ? ~user_init_clock : 1'b0;
  // external pull-up when the device releases the line
  assign ready_line = ready_status_oe_n ? 1'b1 : ready_status_out;
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      bad_count++;
      close_out();
    end
  end

  psc_config_sequencer #(.POR_FAST_CYCLES(20), .POR_STD_CYCLES(40), .STATUS_MIN_CYCLES(60),
    .USER_INIT_CYCLES(5)) uut (.mclk(mclk), .rst(rst), .supplies_valid(supplies_valid),
    .config_request_n(config_request_n), .scheme_select_pins(scheme_select_pins),
    .use_user_init_clock(use_user_init_clock), .user_init_clock(user_init_clock),
    .core_load_done(core_load_done), .core_word_ready(core_word_ready), .config_clock(config_clock),
    .config_data(config_data), .ready_status_out(ready_status_out), .ready_status_oe_n(ready_status_oe_n),
    .load_complete(load_complete), .user_mode(user_mode), .core_word_valid(core_word_valid),
    .core_word_data(core_word_data), .load_overrun(load_overrun));

  psc_host_model host (.send(send), .wide(scheme_select_pins[1]), .word(word), .config_clock(config_clock),
    .config_data(config_data), .busy(busy));

  // ---------------------------------------------------------------
  // compare helpers and verdict
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // cycle counts are the bench's own, so plain ints suffice here
  task automatic chk_rng(input int n, input int lo, input int hi, input string what);
    num_checks++;
    if (n < lo || n > hi)
    begin
      bad_count++;
      $display("mismatch at %0t: %s took %0d cycles, wanted %0d..%0d", $time, what, n, lo, hi);
    end
  endtask : chk_rng

  task automatic close_out();
    if (bad_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // counts mclk cycles until the ready line reads high, capped
  task automatic wait_ready(output int n);
    n = 0;
    while (ready_line !== 1'b1 && n < 300)
    begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_ready

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_por(input logic [2:0] straps, input int exp);
    int n;
    rst = 1'b1;
    supplies_valid = 1'b0;
    scheme_select_pins = straps;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk(ready_line, 1'b0, "ready during power-on");
    supplies_valid = 1'b1;
    wait_ready(n);
    // pin synchroniser adds a few cycles on top of the count
    chk_rng(n, exp, exp + 4, "power-on delay");
  endtask : t_por

  task automatic t_load(input logic [31:0] a, input logic [31:0] b);
    repeat (40) @(negedge mclk);
    core_word_ready = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      word = i ? b : a;
      send = 1'b1;
      @(negedge mclk);
      send = 1'b0;
      for (int k = 0; k < 40 && busy; k++) @(negedge mclk);
      repeat (12) @(negedge mclk);
    end
    // both words held by the two-entry buffer while the core stalls
    for (int i = 0; i < 2; i++)
    begin
      chk(core_word_valid, 1'b1, "word offered");
      chk(core_word_data.data, i ? b : a, "word content");
      core_word_ready = 1'b1;
      @(negedge mclk);
      core_word_ready = 1'b0;
    end
    chk(core_word_valid, 1'b0, "buffer drained");
    chk(load_overrun, 1'b0, "no overrun");
  endtask : t_load

  task automatic t_init(input logic user_clk, input int lo, input int hi);
    int n;
    use_user_init_clock = user_clk;
    core_load_done = 1'b1;
    @(negedge mclk);
    core_load_done = 1'b0;
    chk(load_complete, 1'b1, "load complete raised");
    usr_en = user_clk;
    n = 1;
    while (user_mode !== 1'b1 && n < 4000)
    begin
      @(negedge mclk);
      n++;
    end
    chk_rng(n, lo, hi, "entry to user mode");
  endtask : t_init

  task automatic t_restart(input int hold, input int lo, input int hi);
    int n;
    int m;
    config_request_n = 1'b0;
    n = 0;
    while (ready_line !== 1'b0 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    // 600 ns is twelve cycles from the pin
    chk_rng(n, 0, 12, "ready pulled low");
    chk(load_complete, 1'b0, "load complete dropped");
    chk(user_mode, 1'b0, "user mode left");
    repeat (hold - n) @(negedge mclk);
    config_request_n = 1'b1;
    wait_ready(m);
    chk_rng(hold + m, lo, hi, "restart low time");
  endtask : t_restart

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    t_por(3'h1, 20);
    t_load(32'h1234abcd, 32'h0f1e2d3c);
    t_init(1'b0, 3500, 3502);
    t_restart(40, 60, 66);
    t_restart(150, 151, 155);
    repeat (psc_pkg::READY_MAX_CYC) @(negedge mclk);
    t_load(32'hfedc0123, 32'h89abcdef);
    t_init(1'b1, 16, 28);
    t_por(3'h2, 40);
    t_load(32'ha5a55a5a, 32'h00ff00ff);
    close_out();
  end
endmodule : passive_serial_config_sequencer_tb

/* File: bench/psc_host_model.sv */
// behavioural configuration host: clocks one word onto the link per send pulse
// assumes the bench raises send only once the ready line has been high long enough
`timescale 1ns/10ps
module psc_host_model (
  input wire logic send,
  input wire logic wide,
  input wire logic [31:0] word,
  output logic config_clock,
  output logic [31:0] config_data,
  output logic busy
);
  // ---------------------------------------------------------------
  // link frame driver, 48 ns period, clock idles low between frames
  // ---------------------------------------------------------------
  initial
  begin
    config_clock = 1'b0;
    config_data = 32'h0;
    busy = 1'b0;
  end

  // data set while clock low, rise captures; ready line not sampled
  always @(posedge send)
  begin
    busy = 1'b1;
    for (int i = 0; i < (wide ? 1 : 8); i++)
    begin
      // unused upper lanes toggle so stale values never look valid
      config_data = wide ? word : {~config_data[31:4], word[4*i +: 4]};
      #24 config_clock = 1'b1;
      #24 config_clock = 1'b0;
    end
    // released lines show the inverse, not the last word
    config_data = ~config_data;
    busy = 1'b0;
  end
endmodule : psc_host_model

/* File: design/psc_buf.sv */
// small shift buffer with valid/ready on both sides
// assumes one clock; head entry is the output register
`timescale 1ns/10ps
module psc_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [DEPTH-1:0] vld_reg; // slot occupied
  logic [DEPTH-1:0] vld_next;
  logic ready_reg; // registered so the filling side sees no comb path
  logic placed;

  // pop shifts toward slot zero, push lands in the first free slot
  always_comb
  begin
    placed = 1'b0;
    mem_next = mem_reg;
    vld_next = vld_reg;
    if (out_ready && vld_reg[0])
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        mem_next[i] = mem_reg[i+1];
        vld_next[i] = vld_reg[i+1];
      end
      vld_next[DEPTH-1] = 1'b0;
    end
    if (in_valid && ready_reg)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (!vld_next[i] && !placed)
        begin
          mem_next[i] = in_data;
          vld_next[i] = 1'b1;
          placed = 1'b1;
        end
      end
    end
  end

  // register the buffer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vld_reg <= '0;
      ready_reg <= 1'b0;
      for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
    end
    else
    begin
      vld_reg <= vld_next;
      ready_reg <= !vld_next[DEPTH-1];
      mem_reg <= mem_next;
    end
  end

  assign in_ready = ready_reg;
  assign out_valid = vld_reg[0];
  assign out_data = mem_reg[0];

endmodule : psc_buf

/* File: design/psc_config_sequencer.sv */
// power-up, restart, bitstream capture and user-mode hand-over of the config core
// assumes pins are asynchronous to mclk and config_clock comes from the host only
`timescale 1ns/10ps

// How it works
// - fast power-on holds ready low 4-12 ms
// - standard power-on holds ready low 100-300 ms
// - select pins choose fast or standard delay
// - request low drops load complete quickly
// - request low pulls ready low quickly
// - restart keeps ready low 268-1506 us
// - ready released within 1506 us of request
// - data captured on config clock rising edges
// - both 4-bit serial and 32-bit parallel loading
// - internal init takes 175 to 437 us
// - user clock init counts 8576 cycles
module psc_config_sequencer #(
  parameter int POR_FAST_CYCLES = psc_pkg::POR_FAST_CYC,
  parameter int POR_STD_CYCLES = psc_pkg::POR_STD_CYC,
  parameter int STATUS_MIN_CYCLES = psc_pkg::STATUS_MIN_CYC,
  parameter int USER_INIT_CYCLES = psc_pkg::USER_INIT_CLOCK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic supplies_valid,
  input wire logic config_request_n,
  input wire logic [2:0] scheme_select_pins,
  input wire logic use_user_init_clock,
  input wire logic user_init_clock,
  input wire logic core_load_done,
  input wire logic core_word_ready,
  input wire logic config_clock,
  input wire logic [31:0] config_data,
  output logic ready_status_out,
  output logic ready_status_oe_n,
  output logic load_complete,
  output logic user_mode,
  output logic core_word_valid,
  output psc_pkg::psc_word_t core_word_data,
  output logic load_overrun
);

  // ---------------------------------------------------------------
  // pin synchronisers into mclk
  // ---------------------------------------------------------------
  logic sup_s; // supplies valid
  logic req_n_s; // request line, active low
  logic [2:0] sel_s; // scheme select levels
  logic usr_clk_s; // user init clock as a sampled level
  logic req_tog_s; // word toggle from the link side
  logic req_tog_reg; // link side: flips once per offered word

  psc_sync2 #(.WIDTH(7)) u_sync_pins (
    .clk(mclk),
    .din({supplies_valid, config_request_n, scheme_select_pins, user_init_clock, req_tog_reg}),
    .dout({sup_s, req_n_s, sel_s, usr_clk_s, req_tog_s})
  );

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  psc_pkg::psc_state_t st_reg; // main phase
  psc_pkg::psc_state_t st_next;
  logic [psc_pkg::CNT_W-1:0] cnt_reg; // delay counter of the current phase
  logic [psc_pkg::CNT_W-1:0] cnt_next;
  logic [13:0] usr_cnt_reg; // user clock edges seen during init
  logic [13:0] usr_cnt_next;
  logic usr_prev_reg; // last sampled user clock level
  psc_pkg::psc_scheme_t scheme_reg; // latched select straps
  psc_pkg::psc_scheme_t scheme_next;
  logic oe_n_reg; // low while pulling the ready line down
  logic oe_n_next;
  logic done_reg; // load complete pin
  logic done_next;
  logic user_reg; // user mode flag
  logic user_next;
  logic load_en_reg; // capture window, crosses to the link
  logic load_en_next;
  logic usr_edge;
  logic [psc_pkg::CNT_W-1:0] cnt_inc;
  logic [psc_pkg::CNT_W-1:0] por_tgt;

  // saturating step so a stuck phase never wraps into an early release
  assign cnt_inc = (cnt_reg == '1) ? cnt_reg : cnt_reg + 1'b1;
  assign usr_edge = usr_clk_s && !usr_prev_reg;
  assign por_tgt = scheme_reg.por_fast ? psc_pkg::CNT_W'(POR_FAST_CYCLES - 1)
                                       : psc_pkg::CNT_W'(POR_STD_CYCLES - 1);

  // next-state of the power-up and restart sequence
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_inc;
    usr_cnt_next = usr_cnt_reg;
    scheme_next = scheme_reg;
    oe_n_next = oe_n_reg;
    done_next = done_reg;
    user_next = user_reg;
    unique case (st_reg)
      psc_pkg::PSC_ST_POR:
      begin
        // hold ready low; straps are caught until supplies come up
        oe_n_next = 1'b0;
        done_next = 1'b0;
        user_next = 1'b0;
        if (!sup_s)
        begin
          cnt_next = '0;
          scheme_next = psc_pkg::psc_decode(sel_s);
        end
        else if (cnt_reg >= por_tgt)
        begin
          st_next = psc_pkg::PSC_ST_LOAD;
          oe_n_next = 1'b1;
          cnt_next = '0;
        end
      end
      psc_pkg::PSC_ST_RESTART:
      begin
        oe_n_next = 1'b0;
        done_next = 1'b0;
        user_next = 1'b0;
        if (req_n_s && cnt_reg >= psc_pkg::CNT_W'(STATUS_MIN_CYCLES - 1))
        begin
          st_next = psc_pkg::PSC_ST_LOAD;
          oe_n_next = 1'b1;
          cnt_next = '0;
        end
      end
      psc_pkg::PSC_ST_LOAD:
      begin
        // the core knows the stream end; compressed streams vary in length
        if (core_load_done)
        begin
          st_next = psc_pkg::PSC_ST_INIT;
          done_next = 1'b1;
          cnt_next = '0;
          usr_cnt_next = '0;
        end
      end
      psc_pkg::PSC_ST_INIT:
      begin
        if (use_user_init_clock)
        begin
          if (usr_edge)
          begin
            usr_cnt_next = usr_cnt_reg + 1'b1;
            if (usr_cnt_reg == 14'(USER_INIT_CYCLES - 1))
            begin
              st_next = psc_pkg::PSC_ST_USER;
              user_next = 1'b1;
            end
          end
        end
        else if (cnt_reg == psc_pkg::CNT_W'(psc_pkg::INIT_MIN_CYC - 1))
        begin
          st_next = psc_pkg::PSC_ST_USER;
          user_next = 1'b1;
        end
      end
      psc_pkg::PSC_ST_USER:
      begin
        user_next = 1'b1;
      end
      default:
      begin
        st_next = psc_pkg::PSC_ST_POR;
        cnt_next = '0;
      end
    endcase
    // a request pulse restarts from any phase except power-on
    // load complete drops
    if (!req_n_s && st_reg != psc_pkg::PSC_ST_POR)
    begin
      st_next = psc_pkg::PSC_ST_RESTART;
      oe_n_next = 1'b0;
      done_next = 1'b0;
      user_next = 1'b0;
      if (st_reg != psc_pkg::PSC_ST_RESTART) cnt_next = '0;
    end
    // losing a supply falls back to power-on
    if (!sup_s)
    begin
      st_next = psc_pkg::PSC_ST_POR;
      oe_n_next = 1'b0;
      done_next = 1'b0;
      user_next = 1'b0;
      cnt_next = '0;
    end
    load_en_next = (st_next == psc_pkg::PSC_ST_LOAD);
  end

  // register the sequence
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_reg <= psc_pkg::PSC_ST_POR;
      cnt_reg <= '0;
      usr_cnt_reg <= '0;
      usr_prev_reg <= 1'b0;
      scheme_reg <= '0;
      oe_n_reg <= psc_pkg::RST_STATUS_OE_N;
      done_reg <= psc_pkg::RST_LOAD_COMPLETE;
      user_reg <= 1'b0;
      load_en_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      usr_cnt_reg <= usr_cnt_next;
      usr_prev_reg <= usr_clk_s;
      scheme_reg <= scheme_next;
      oe_n_reg <= oe_n_next;
      done_reg <= done_next;
      user_reg <= user_next;
      load_en_reg <= load_en_next;
    end
  end

  // ---------------------------------------------------------------
  // link domain on config_clock
  // ---------------------------------------------------------------
  logic link_clr; // window shut: clears the link side at once
  logic wide_l; // parallel width select, steady while the window is open
  logic [31:0] asm_reg; // nibble assembly
  logic [31:0] asm_next;
  logic [2:0] nib_reg; // nibbles taken into the word
  logic [2:0] nib_next;
  logic [31:0] hold_reg; // word offered across, stable while pending
  logic [31:0] hold_next;
  logic req_tog_next;
  logic word_done;
  logic [31:0] word_val;

  // the host may stop its clock between frames, so no link edge is needed to learn the window;
  // the clear lets go while the clock is still, as no edge comes within 2 us of ready rising
  assign link_clr = !load_en_reg;
  // straps only change in power-on, while the window is shut
  assign wide_l = scheme_reg.wide;

  always_comb
  begin
    asm_next = asm_reg;
    nib_next = nib_reg;
    hold_next = hold_reg;
    req_tog_next = req_tog_reg;
    word_done = 1'b0;
    word_val = config_data;
    // outside the window the clear holds the assembly at its start
    if (wide_l)
    begin
      word_done = 1'b1;
    end
    else
    begin
      // first nibble ends up in the low bits
      asm_next = {config_data[psc_pkg::SERIAL_WIDTH-1:0], asm_reg[31:psc_pkg::SERIAL_WIDTH]};
      word_val = asm_next;
      nib_next = nib_reg + 1'b1;
      word_done = (nib_reg == psc_pkg::NIB_LAST);
    end
    if (word_done)
    begin
      // the host cannot be stalled, so a word with no room is flagged on the mclk side
      hold_next = word_val;
      req_tog_next = !req_tog_reg;
    end
  end

  // register the link side; cleared at once when the window shuts
  always_ff @(posedge config_clock or posedge link_clr)
  begin
    if (link_clr)
    begin
      asm_reg <= '0;
      nib_reg <= '0;
      hold_reg <= '0;
      req_tog_reg <= 1'b0;
    end
    else
    begin
      asm_reg <= asm_next;
      nib_reg <= nib_next;
      hold_reg <= hold_next;
      req_tog_reg <= req_tog_next;
    end
  end

  // ---------------------------------------------------------------
  // word hand-off and buffer in mclk
  // ---------------------------------------------------------------
  logic seen_reg; // last toggle taken
  logic seen_next;
  logic overrun_reg; // a word came with the buffer full, held until the window shuts
  logic overrun_next;
  logic take; // a new word stands across the crossing
  logic buf_ready;
  logic push;

  assign take = (req_tog_s != seen_reg);
  // words that arrive outside the window are taken and dropped
  assign push = take && buf_ready && load_en_reg;

  // every toggle is taken at once: the link side may overwrite its hold register with the next word
  always_comb
  begin
    seen_next = seen_reg;
    overrun_next = overrun_reg && load_en_reg;
    if (take)
    begin
      seen_next = req_tog_s;
      if (load_en_reg && !buf_ready) overrun_next = 1'b1;
    end
  end

  // register the hand-off state
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      seen_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end
    else
    begin
      seen_reg <= seen_next;
      overrun_reg <= overrun_next;
    end
  end

  psc_buf #(.WIDTH(psc_pkg::PARALLEL_WIDTH), .DEPTH(psc_pkg::BUF_DEPTH)) u_buf (
    .clk(mclk),
    .rst(rst),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(hold_reg),
    .out_valid(core_word_valid),
    .out_ready(core_word_ready),
    .out_data(core_word_data)
  );

  // open-drain ready line, only pulled low
  always_ff @(posedge mclk)
  begin
    ready_status_out <= 1'b0;
  end

  assign ready_status_oe_n = oe_n_reg;
  assign load_complete = done_reg;
  assign user_mode = user_reg;
  assign load_overrun = overrun_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [psc_pkg::CNT_W-1:0] por_len_reg; // powered cycles in power-on
  logic [psc_pkg::CNT_W-1:0] low_len_reg; // cycles the ready line is held low
  logic [psc_pkg::CNT_W-1:0] hi_len_reg; // cycles since request high in restart
  logic [psc_pkg::CNT_W-1:0] init_len_reg; // cycles spent in init

  // cycle counters read only by the checks
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      por_len_reg <= '0;
      low_len_reg <= '0;
      hi_len_reg <= '0;
      init_len_reg <= '0;
    end
    else
    begin
      por_len_reg <= (st_reg == psc_pkg::PSC_ST_POR && sup_s) ? por_len_reg + 1'b1 : '0;
      low_len_reg <= !oe_n_reg ? low_len_reg + 1'b1 : '0;
      hi_len_reg <= (st_reg == psc_pkg::PSC_ST_RESTART && req_n_s) ? hi_len_reg + 1'b1 : '0;
      init_len_reg <= (st_reg == psc_pkg::PSC_ST_INIT) ? init_len_reg + 1'b1 : '0;
    end
  end

  sequence s_ready_rise;
    $rose(oe_n_reg) && sup_s;
  endsequence

  sequence s_nibble_word;
    !wide_l && nib_reg == psc_pkg::NIB_LAST;
  endsequence

  AST_POR_FAST: assert property (@(posedge mclk) disable iff (rst)
    s_ready_rise and ($past(st_reg) == psc_pkg::PSC_ST_POR) and scheme_reg.por_fast
    |-> por_len_reg == psc_pkg::CNT_W'(POR_FAST_CYCLES)) else $error("fast power-on delay wrong");
  AST_POR_STD: assert property (@(posedge mclk) disable iff (rst)
    s_ready_rise and ($past(st_reg) == psc_pkg::PSC_ST_POR) and !scheme_reg.por_fast
    |-> por_len_reg == psc_pkg::CNT_W'(POR_STD_CYCLES)) else $error("standard power-on delay wrong");
  AST_STRAP: assert property (@(posedge mclk) disable iff (rst)
    (st_reg == psc_pkg::PSC_ST_POR && !sup_s) |=> scheme_reg == psc_pkg::psc_decode($past(sel_s)))
    else $error("straps not caught");
  AST_DONE_DROP: assert property (@(posedge mclk) disable iff (rst)
    ($fell(req_n_s) && sup_s && st_reg != psc_pkg::PSC_ST_POR) |-> ##1 !done_reg [*2])
    else $error("load complete not dropped");
  AST_READY_PULL: assert property (@(posedge mclk) disable iff (rst)
    ($fell(req_n_s) && sup_s) |-> ##1 !oe_n_reg) else $error("ready not pulled low");
  AST_STATUS_LOW: assert property (@(posedge mclk) disable iff (rst)
    s_ready_rise and ($past(st_reg) == psc_pkg::PSC_ST_RESTART)
    |-> low_len_reg >= psc_pkg::CNT_W'(STATUS_MIN_CYCLES)) else $error("restart low pulse too short");
  AST_READY_BOUND: assert property (@(posedge mclk) disable iff (rst)
    (st_reg == psc_pkg::PSC_ST_RESTART && req_n_s)
    |-> hi_len_reg <= psc_pkg::CNT_W'(psc_pkg::READY_MAX_CYC)) else $error("ready released late");
  AST_INIT_OSC: assert property (@(posedge mclk) disable iff (rst)
    ($rose(user_reg) && !use_user_init_clock)
    |-> init_len_reg >= psc_pkg::CNT_W'(psc_pkg::INIT_MIN_CYC)
     && init_len_reg <= psc_pkg::CNT_W'(psc_pkg::INIT_MAX_CYC)) else $error("init time out of range");
  AST_INIT_USR: assert property (@(posedge mclk) disable iff (rst)
    ($rose(user_reg) && use_user_init_clock) |-> usr_cnt_reg == 14'(USER_INIT_CYCLES))
    else $error("user clock init count wrong");
  AST_NIBBLES: assert property (@(posedge config_clock) disable iff (link_clr)
    s_nibble_word |=> (req_tog_reg != $past(req_tog_reg)) && nib_reg == '0)
    else $error("serial word not offered");
  AST_WIDE: assert property (@(posedge config_clock) disable iff (link_clr)
    wide_l |=> hold_reg == $past(config_data))
    else $error("parallel word not captured");

endmodule : psc_config_sequencer

/* File: design/psc_pkg.sv */
// shared constants, types and decoders of the passive configuration sequencer
// assumes a 20 MHz system clock; link-side timing is set by the external host
package psc_pkg;

  // ---------------------------------------------------------------
  // clock and timing figures
  // ---------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 50;
  localparam int POR_FAST_MIN_MS = 4;
  localparam int POR_FAST_MAX_MS = 12;
  localparam int POR_STD_MIN_MS = 100;
  localparam int POR_STD_MAX_MS = 300;
  localparam int REQ_TO_DROP_MAX_NS = 600;
  localparam int STATUS_LOW_MIN_US = 268;
  localparam int STATUS_LOW_MAX_US = 1506;
  localparam int REQ_HIGH_TO_READY_MAX_US = 1506;
  localparam int DONE_TO_USER_MIN_US = 175;
  localparam int DONE_TO_USER_MAX_US = 437;
  localparam int USER_INIT_CLOCK_CYCLES = 8576;

  // least times round up, longest times round down, never below one cycle
  function automatic int cyc_ceil(input int ns);
    cyc_ceil = (ns + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    if (cyc_ceil < 1) cyc_ceil = 1;
  endfunction : cyc_ceil

  function automatic int cyc_floor(input int ns);
    cyc_floor = ns / MCLK_PERIOD_NS;
    if (cyc_floor < 1) cyc_floor = 1;
  endfunction : cyc_floor

  localparam int POR_FAST_CYC = cyc_ceil(POR_FAST_MIN_MS * 1000000);
  localparam int POR_FAST_MAX_CYC = cyc_floor(POR_FAST_MAX_MS * 1000000);
  localparam int POR_STD_CYC = cyc_ceil(POR_STD_MIN_MS * 1000000);
  localparam int POR_STD_MAX_CYC = cyc_floor(POR_STD_MAX_MS * 1000000);
  localparam int REQ_TO_DROP_CYC = cyc_floor(REQ_TO_DROP_MAX_NS);
  localparam int STATUS_MIN_CYC = cyc_ceil(STATUS_LOW_MIN_US * 1000);
  localparam int STATUS_MAX_CYC = cyc_floor(STATUS_LOW_MAX_US * 1000);
  localparam int READY_MAX_CYC = cyc_floor(REQ_HIGH_TO_READY_MAX_US * 1000);
  localparam int INIT_MIN_CYC = cyc_ceil(DONE_TO_USER_MIN_US * 1000);
  localparam int INIT_MAX_CYC = cyc_floor(DONE_TO_USER_MAX_US * 1000);

  // ---------------------------------------------------------------
  // widths, positions and reset values
  // ---------------------------------------------------------------
  localparam int SERIAL_WIDTH = 4;
  localparam int PARALLEL_WIDTH = 32;
  localparam int CNT_W = 22;
  localparam int BUF_DEPTH = 2;
  localparam logic [2:0] NIB_LAST = 3'h7;
  localparam int SEL_POR_FAST_BIT = 0;
  localparam int SEL_WIDE_BIT = 1;
  localparam logic RST_LOAD_COMPLETE = 1'b0;
  localparam logic RST_STATUS_OE_N = 1'b0;

  typedef enum logic [2:0] {
    PSC_ST_POR = 3'b000,
    PSC_ST_RESTART = 3'b001,
    PSC_ST_LOAD = 3'b010,
    PSC_ST_INIT = 3'b011,
    PSC_ST_USER = 3'b100
  } psc_state_t;

  typedef struct packed {
    logic wide;
    logic por_fast;
  } psc_scheme_t;

  typedef struct packed {
    logic [PARALLEL_WIDTH-1:0] data;
  } psc_word_t;

  function automatic psc_scheme_t psc_decode(input logic [2:0] pins);
    psc_decode.wide = pins[SEL_WIDE_BIT];
    psc_decode.por_fast = pins[SEL_POR_FAST_BIT];
  endfunction : psc_decode

endpackage : psc_pkg

/* File: design/psc_sync2.sv */
// two-stage level synchroniser, vector wide
// assumes each bit is a slow level or a toggle; no reset so nothing gates stage one
`timescale 1ns/10ps
module psc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ---------------------------------------------------------------
  // stages
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_reg; // first stage, read only by the second

  // plain double flop
  always_ff @(posedge clk)
  begin
    meta_reg <= din;
    dout <= meta_reg;
  end

endmodule : psc_sync2
